/* File: uts_defs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  USB token/status register block.
  Assumes inclusion by bare name from the package, the checker and the bench.
*/
`ifndef UTS_DEFS_SVH
`define UTS_DEFS_SVH

// Register byte offsets
`define UTS_OFF_SOF 8'h28
`define UTS_OFF_PID 8'h2c
`define UTS_OFF_EP 8'h30
`define UTS_OFF_EPMARK 8'h34
`define UTS_OFF_OTGMASK 8'h38
`define UTS_OFF_PWRSIG 8'h3c
`define UTS_OFF_XCTL 8'h40
`define UTS_OFF_IRQ_STAT 8'h44
`define UTS_OFF_IRQ_MASK 8'h48
`define UTS_OFF_LINE 8'h4c

// Field positions
`define UTS_EP_VALID_BIT 4
`define UTS_EP_MARK_OR 5'h10
`define UTS_XCTL_PD_DIS 18
`define UTS_XCTL_RST_FLAG 13
`define UTS_XCTL_RES_FLAG 12
`define UTS_XCTL_FILT_HI 11
`define UTS_XCTL_FILT_LO 8
`define UTS_XCTL_AUTORES 7
`define UTS_XCTL_CONF_HI 6
`define UTS_XCTL_CONF_LO 4
`define UTS_XCTL_WMASK 32'h0004_f0f0

// Reset values
`define UTS_RST_ZERO 32'h0000_0000

// Suspend detect: 3 ms of idle J state at 20 MHz
`define UTS_SUSPEND_US 3000
`define UTS_CLK_MHZ 20
`define UTS_SUSPEND_CYC (`UTS_SUSPEND_US * `UTS_CLK_MHZ)

// Packet identifiers of interest
`define UTS_PID_SOF 4'h5
`define UTS_PID_OUT 4'h1
`define UTS_PID_IN 4'h9
`define UTS_PID_SETUP 4'hd

`endif

/* File: uts_pkg.sv */
/*
  Types shared by the USB token/status register block.
  Assumes uts_defs.svh is on the include path.
*/
package uts_pkg;
  `include "uts_defs.svh"

  // Line state encoding as seen on the transceiver
  typedef enum logic [1:0] {
    UTS_LS_SE0 = 2'h0,
    UTS_LS_J = 2'h1,
    UTS_LS_K = 2'h2,
    UTS_LS_SE1 = 2'h3
  } uts_line_e;

  // Suspend controller states, one-hot
  typedef enum logic [2:0] {
    UTS_SC_ACTIVE = 3'b001,
    UTS_SC_SUSPEND = 3'b010,
    UTS_SC_WAKE = 3'b100
  } uts_susp_e;
endpackage

/* File: uts_sync.sv */
/*
  Three-stage synchroniser with agreement filter for a pin input.
  Assumes the input is asynchronous to i_sys_clk.
*/
`timescale 1ns/1ps
module uts_sync
  import uts_pkg::*;
#(
  parameter int WIDTH = 2, // Bits synchronised
  parameter logic [WIDTH-1:0] RST_VAL = '0 // Idle level held through reset
)
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic [WIDTH-1:0] i_async, // Raw pin level
  output logic [WIDTH-1:0] o_sync // Settled level
);
  // All state of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } uts_sync_s;

  uts_sync_s st;
  uts_sync_s next_st;

  // Stage one feeds only stage two; change counts once stages two and three agree
  always_comb
  begin
    next_st = st;
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.out = st.s3;
    end
  end

  // State register; resets to the pin's idle level so no false edge follows reset
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      st <= {4{RST_VAL}};
    else
      st <= next_st;
  end

  assign o_sync = st.out;
endmodule

/* File: uts_line_filter.sv */
/*
  Line-state change filter: a new line state propagates only after holding
  stable for 2**N clocks.
  Assumes a synchronised line state input.
*/
`timescale 1ns/1ps
module uts_line_filter
  import uts_pkg::*;
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic [1:0] i_line, // Synchronised line state
  input wire logic [3:0] i_log2, // Log2 of the delay
  output logic [1:0] o_line // Filtered line state
);
  // All state of the filter
  typedef struct packed {
    logic [1:0] cand;
    logic [15:0] cnt;
    logic [1:0] out;
  } uts_filt_s;

  uts_filt_s st;
  uts_filt_s next_st;
  logic [16:0] target;

  // Count stable cycles of a candidate state before passing it on
  always_comb
  begin
    next_st = st;
    target = 17'h0_0001 << i_log2;
    if (i_line != st.cand)
    begin
      // Any bounce restarts the wait
      next_st.cand = i_line;
      next_st.cnt = 16'h0001;
    end
    else if (st.out != st.cand)
    begin
      if ({1'b0, st.cnt} >= target)
        next_st.out = st.cand; // [RL9]
      else
        next_st.cnt = st.cnt + 16'h0001;
    end
  end

  // State register; reset state is J (idle)
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      st <= '{cand: 2'h1, cnt: 16'h0000, out: 2'h1};
    else
      st <= next_st;
  end

  assign o_line = st.out;
endmodule

/* File: uts_regs.sv */
/*
  USB token/status register block of the USB interface engine: frame count,
  last packet identifier, last endpoint, endpoint marks, transceiver control
  and the auto-resume handler, with a sticky interrupt status.
  Assumes decoded tokens arrive as one-cycle strobes on the system clock and
  the transceiver line state arrives asynchronously on pins.
*/
// Our own choice: strobed register access.
// Summary of operation
// [RL1] Eleven-bit frame counter, writable, split 10:8/7:0
// [RL2] Last received packet identifier in bits 3:0
// [RL3] Last token endpoint number in bits 3:0
// [RL4] Bit 4 flags endpoint field holds valid value
// [RL5] Marked endpoints presented on receive port ORed 0x10
// [RL6] Control bit 18 disables data port pulldowns
// [RL7] SE0 auto-resume sets bit 13, write zero clears
// [RL8] K auto-resume sets bit 12, write zero clears
// [RL9] Line-state change delayed two-to-the-N clocks
// [RL10] Bit 7 enables hardware resume from suspend
// [RL11] Bits 6:4 drive transceiver configuration pins
// [RL12] Good start-of-frame token loads frame counter
`timescale 1ns/1ps
module uts_regs
  import uts_pkg::*;
#(
  parameter int SUSPEND_CYC = `UTS_SUSPEND_CYC, // Idle cycles before suspend
  parameter int EP_COUNT = 16 // Number of endpoints
)
(
  input wire logic i_sys_clk, // System clock, 20 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_pkt_valid, // Packet identifier received, pulse
  input wire logic [3:0] i_pkt_pid, // Packet identifier
  input wire logic i_tok_valid, // Good token decoded, pulse
  input wire logic [3:0] i_tok_ep, // Token endpoint number
  input wire logic [10:0] i_tok_frame, // Frame number of a start-of-frame token
  output logic [4:0] o_rx_ep, // Endpoint on the receive port
  output logic o_rx_ep_valid, // Receive port endpoint strobe
  input wire logic [1:0] i_line_pin, // Raw line state from transceiver
  output logic [1:0] o_line_filt, // Filtered line state
  output logic o_usb_data_port_a_pd_en, // Pulldown enable, data port a
  output logic o_usb_data_port_b_pd_en, // Pulldown enable, data port b
  output logic [2:0] o_transceiver_config_pins, // Transceiver config pins
  output logic o_suspended, // Suspend controller in suspend
  output logic o_irq // Level interrupt
);
  // Elaboration check on parameters
  if (EP_COUNT != 16 || SUSPEND_CYC < 2 || SUSPEND_CYC > 32'h00ff_ffff)
  begin : g_param_check
    $error("uts_regs: unsupported parameter values");
  end

  // All state of the block
  typedef struct packed {
    logic [10:0] frame;
    logic [3:0] pid;
    logic [3:0] ep;
    logic ep_valid;
    logic [15:0] ep_mark;
    logic [31:0] otg_mask;
    logic [8:0] pwr_sig;
    logic pd_dis;
    logic rst_flag;
    logic res_flag;
    logic [3:0] filt_log2;
    logic autores;
    logic [2:0] conf;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    uts_susp_e susp;
    logic [23:0] idle_cnt;
    logic [1:0] line_q;
    logic [4:0] rx_ep;
    logic rx_ep_valid;
    logic [31:0] rdata;
    logic irq;
    logic pd_en;
    logic suspended;
  } uts_regs_s;

  uts_regs_s st;
  uts_regs_s next_st;
  logic [1:0] line_sync;
  logic [1:0] line_filt;
  logic [31:0] xctl_rd;
  logic [2:0] irq_ev;
  logic rd_stat;

  // Pin input through three flops with agreement
  uts_sync #(
    .WIDTH(2),
    .RST_VAL(2'h1) // Idle J, matches the filter's reset state
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async(i_line_pin),
    .o_sync(line_sync)
  );

  // Programmable line-state change delay
  uts_line_filter u_filt (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_line(line_sync),
    .i_log2(st.filt_log2), // [RL9]
    .o_line(line_filt)
  );

  // Read view of the transceiver control register
  always_comb
  begin
    xctl_rd = `UTS_RST_ZERO;
    xctl_rd[`UTS_XCTL_PD_DIS] = st.pd_dis;
    xctl_rd[`UTS_XCTL_RST_FLAG] = st.rst_flag;
    xctl_rd[`UTS_XCTL_RES_FLAG] = st.res_flag;
    xctl_rd[`UTS_XCTL_FILT_HI:`UTS_XCTL_FILT_LO] = st.filt_log2;
    xctl_rd[`UTS_XCTL_AUTORES] = st.autores;
    xctl_rd[`UTS_XCTL_CONF_HI:`UTS_XCTL_CONF_LO] = st.conf;
  end

  // Next-state logic: bus, token capture, suspend controller, interrupts
  always_comb
  begin
    next_st = st;
    irq_ev = 3'h0;
    rd_stat = i_rd && (i_addr == `UTS_OFF_IRQ_STAT);
    next_st.line_q = line_filt;
    next_st.rx_ep_valid = 1'b0;

    // Register writes first, so hardware events below take priority
    if (i_wr)
    begin
      case (i_addr)
        `UTS_OFF_SOF: next_st.frame = i_wdata[10:0]; // [RL1]
        `UTS_OFF_EPMARK: next_st.ep_mark = i_wdata[15:0]; // [RL5]
        `UTS_OFF_OTGMASK: next_st.otg_mask = i_wdata;
        `UTS_OFF_PWRSIG: next_st.pwr_sig = i_wdata[8:0];
        `UTS_OFF_XCTL:
        begin
          next_st.pd_dis = i_wdata[`UTS_XCTL_PD_DIS]; // [RL6]
          // Flags only clear by writing zero; writing one leaves them alone
          if (!i_wdata[`UTS_XCTL_RST_FLAG])
            next_st.rst_flag = 1'b0; // [RL7]
          if (!i_wdata[`UTS_XCTL_RES_FLAG])
            next_st.res_flag = 1'b0; // [RL8]
          next_st.filt_log2 = i_wdata[`UTS_XCTL_FILT_HI:`UTS_XCTL_FILT_LO];
          next_st.autores = i_wdata[`UTS_XCTL_AUTORES]; // [RL10]
          next_st.conf = i_wdata[`UTS_XCTL_CONF_HI:`UTS_XCTL_CONF_LO]; // [RL11]
        end
        `UTS_OFF_IRQ_MASK: next_st.irq_mask = i_wdata[2:0];
        default: ; // Read-only or unmapped: write ignored
      endcase
    end

    // Packet identifier capture
    if (i_pkt_valid)
    begin
      next_st.pid = i_pkt_pid; // [RL2]
    end

    // Token capture; wins over a same-cycle bus write
    if (i_tok_valid)
    begin
      if (i_pkt_pid == `UTS_PID_SOF)
      begin
        next_st.frame = i_tok_frame; // [RL12]
        irq_ev[0] = 1'b1;
      end
      else
      begin
        next_st.ep = i_tok_ep; // [RL3]
        next_st.ep_valid = 1'b1; // [RL4]
        // Marked endpoints carry bit 4 on the receive port
        next_st.rx_ep = st.ep_mark[i_tok_ep] ? ({1'b0, i_tok_ep} | `UTS_EP_MARK_OR) : {1'b0, i_tok_ep}; // [RL5]
        next_st.rx_ep_valid = 1'b1;
      end
    end

    // Suspend controller: long idle J enters suspend
    case (st.susp)
      UTS_SC_ACTIVE:
      begin
        if (line_filt == UTS_LS_J)
        begin
          if ({8'h00, st.idle_cnt} >= SUSPEND_CYC - 1)
            next_st.susp = UTS_SC_SUSPEND;
          else
            next_st.idle_cnt = st.idle_cnt + 24'h00_0001;
        end
        else
        begin
          next_st.idle_cnt = 24'h00_0000;
        end
      end
      UTS_SC_SUSPEND:
      begin
        // Without auto-resume any non-J line still leaves suspend, but sets no flag and raises no interrupt
        if (st.autores && line_filt == UTS_LS_SE0) // [RL10]
        begin
          next_st.rst_flag = 1'b1; // [RL7]
          irq_ev[1] = 1'b1;
          next_st.susp = UTS_SC_WAKE;
        end
        else if (st.autores && line_filt == UTS_LS_K) // [RL10]
        begin
          next_st.res_flag = 1'b1; // [RL8]
          irq_ev[2] = 1'b1;
          next_st.susp = UTS_SC_WAKE;
        end
        else if (!st.autores && line_filt != UTS_LS_J)
        begin
          next_st.susp = UTS_SC_WAKE;
        end
      end
      UTS_SC_WAKE:
      begin
        next_st.idle_cnt = 24'h00_0000;
        next_st.susp = UTS_SC_ACTIVE;
      end
      default: next_st.susp = UTS_SC_ACTIVE;
    endcase

    // Sticky status: read clears, a same-cycle event survives
    if (rd_stat)
      next_st.irq_stat = irq_ev;
    else
      next_st.irq_stat = st.irq_stat | irq_ev;
    next_st.irq = |(next_st.irq_stat & st.irq_mask);

    // Output copies registered so the pins come straight from flops
    next_st.pd_en = ~next_st.pd_dis; // [RL6]
    next_st.suspended = next_st.susp == UTS_SC_SUSPEND;

    // Read data registered for the following cycle
    next_st.rdata = `UTS_RST_ZERO;
    if (i_rd)
    begin
      case (i_addr)
        `UTS_OFF_SOF: next_st.rdata = {21'h00_0000, st.frame}; // [RL1]
        `UTS_OFF_PID: next_st.rdata = {28'h000_0000, st.pid}; // [RL2]
        `UTS_OFF_EP: next_st.rdata = {27'h000_0000, st.ep_valid, st.ep & {4{st.ep_valid}}}; // [RL4]
        `UTS_OFF_EPMARK: next_st.rdata = {16'h0000, st.ep_mark};
        `UTS_OFF_OTGMASK: next_st.rdata = st.otg_mask;
        `UTS_OFF_PWRSIG: next_st.rdata = {23'h00_0000, st.pwr_sig};
        `UTS_OFF_XCTL: next_st.rdata = xctl_rd;
        `UTS_OFF_IRQ_STAT: next_st.rdata = {29'h0000_0000, st.irq_stat};
        `UTS_OFF_IRQ_MASK: next_st.rdata = {29'h0000_0000, st.irq_mask};
        `UTS_OFF_LINE: next_st.rdata = {29'h0000_0000, st.susp == UTS_SC_SUSPEND, st.line_q};
        default: next_st.rdata = `UTS_RST_ZERO; // Unmapped reads as zero
      endcase
    end
  end

  // State register; everything resets to zero except line_q to J and pd_en to one, controller to active
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st <= '0;
      st.susp <= UTS_SC_ACTIVE;
      st.line_q <= 2'h1;
      st.pd_en <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign o_rdata = st.rdata;
  assign o_rx_ep = st.rx_ep;
  assign o_rx_ep_valid = st.rx_ep_valid;
  assign o_line_filt = st.line_q;
  assign o_usb_data_port_a_pd_en = st.pd_en; // [RL6]
  assign o_usb_data_port_b_pd_en = st.pd_en; // [RL6]
  assign o_transceiver_config_pins = st.conf; // [RL11]
  assign o_suspended = st.suspended;
  assign o_irq = st.irq;
endmodule

/* File: uts_regs_chk.sv */
/*
  Concurrent checks on the ports of uts_regs.
  Assumes the bind at the foot attaches it to every uts_regs instance.
*/
`timescale 1ns/1ps
`include "uts_defs.svh"
module uts_regs_chk
  import uts_pkg::*;
(
  input wire logic i_sys_clk, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic [7:0] i_addr, // Address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [31:0] o_rdata, // Read data
  input wire logic [3:0] i_pkt_pid, // Packet identifier
  input wire logic i_tok_valid, // Token strobe
  input wire logic [3:0] i_tok_ep, // Token endpoint
  input wire logic [4:0] o_rx_ep, // Receive port endpoint
  input wire logic o_rx_ep_valid, // Receive port strobe
  input wire logic [1:0] i_line_pin, // Raw line state
  input wire logic [1:0] o_line_filt, // Filtered line state
  input wire logic o_usb_data_port_a_pd_en, // Pulldown a
  input wire logic o_usb_data_port_b_pd_en, // Pulldown b
  input wire logic [2:0] o_transceiver_config_pins, // Config pins
  input wire logic o_irq // Interrupt
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // Control write then a quiet cycle, so one or two stages of latency both settle
  sequence s_ctl_wr;
    i_wr && i_addr == `UTS_OFF_XCTL;
  endsequence
  sequence s_ctl_quiet;
    !(i_wr && i_addr == `UTS_OFF_XCTL);
  endsequence
  chk_pd_follow: assert property (
    s_ctl_wr ##1 s_ctl_quiet |-> ##1 o_usb_data_port_a_pd_en == !$past(i_wdata[18], 2))
    else $error("pulldown enable does not follow control bit");
  chk_pd_pair: assert property (
    o_usb_data_port_a_pd_en == o_usb_data_port_b_pd_en)
    else $error("pulldown enables disagree");
  chk_conf_pins: assert property (
    s_ctl_wr ##1 s_ctl_quiet |-> ##1 o_transceiver_config_pins == $past(i_wdata[6:4], 2))
    else $error("config pins do not follow control field");
  chk_rx_strobe: assert property (
    o_rx_ep_valid == $past(i_tok_valid && i_pkt_pid != `UTS_PID_SOF))
    else $error("receive strobe not one cycle after token");
  chk_rx_number: assert property (
    o_rx_ep_valid |-> o_rx_ep[3:0] == $past(i_tok_ep))
    else $error("receive endpoint number wrong");
  chk_pid_resv: assert property (
    i_rd && i_addr == `UTS_OFF_PID |=> o_rdata[31:4] == 28'h0)
    else $error("identifier register reserved bits set");
  chk_ep_valid: assert property (
    i_rd && i_addr == `UTS_OFF_EP |=> o_rdata[31:5] == 27'h0 && (o_rdata[4] || o_rdata[3:0] == 4'h0))
    else $error("endpoint register shows number without valid");
  chk_frame_resv: assert property (
    i_rd && i_addr == `UTS_OFF_SOF |=> o_rdata[31:11] == 21'h0)
    else $error("frame register reserved bits set");
  // Sync stages forbid a filtered change before the pin held the new state
  chk_filt_hold: assert property (
    $changed(o_line_filt) |-> $past(i_line_pin) == o_line_filt && $past(i_line_pin, 2) == o_line_filt)
    else $error("filtered line moved ahead of pin");
  chk_irq_drop: assert property (
    $fell(o_irq) |-> i_rd || i_wr || $past(i_rd || i_wr) || $past(i_rd || i_wr, 2))
    else $error("interrupt dropped without bus access");
endmodule
bind uts_regs uts_regs_chk uts_regs_chk_i (.*);

/* File: uts_host_model.sv */
/*
  Behavioural host seen through the transceiver: decoded tokens and line state.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module uts_host_model
  import uts_pkg::*;
(
  input wire logic i_sys_clk, // Clock
  output logic o_pkt_valid, // Packet strobe
  output logic [3:0] o_pkt_pid, // Packet identifier
  output logic o_tok_valid, // Token strobe
  output logic [3:0] o_tok_ep, // Token endpoint
  output logic [10:0] o_tok_frame, // Frame number
  output logic [1:0] o_line_pin // Line state
);
  // Idle bus is J
  initial
  begin
    o_pkt_valid = 1'b0;
    o_tok_valid = 1'b0;
    o_pkt_pid = 4'h0;
    o_tok_ep = 4'h0;
    o_tok_frame = 11'h0;
    o_line_pin = UTS_LS_J;
  end
  // One-cycle token; fields are inverted after, so stale data never looks valid
  task automatic send_token(input logic [3:0] pid, input logic [3:0] ep, input logic [10:0] fr);
    @(posedge i_sys_clk);
    o_pkt_valid <= 1'b1;
    o_tok_valid <= 1'b1;
    o_pkt_pid <= pid;
    o_tok_ep <= ep;
    o_tok_frame <= fr;
    @(posedge i_sys_clk);
    o_pkt_valid <= 1'b0;
    o_tok_valid <= 1'b0;
    o_pkt_pid <= ~pid;
    o_tok_ep <= ~ep;
    o_tok_frame <= ~fr;
  endtask
  // SE0 signals bus reset, K signals resume
  task automatic drive_line(input logic [1:0] ls);
    @(posedge i_sys_clk);
    o_line_pin <= ls;
  endtask
endmodule

/* File: tb.sv */
/*
  Self-checking bench for uts_regs with a host model on the USB side.
  Assumes uts_pkg, uts_defs.svh and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "uts_defs.svh"
module tb;
  import uts_pkg::*;
  logic i_sys_clk, i_resetn, i_wr, i_rd, pv, tv;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d, got;
  logic [3:0] pid, ep, tep, last_ep;
  logic [10:0] fr, tfr;
  logic [1:0] lp, filt;
  logic [4:0] rx_ep;
  logic rx_v, pd_a, pd_b, susp, irq, ep_ok;
  logic [2:0] conf;
  logic [15:0] mark;
  int num_errors, n_tests, cyc;
  logic [3:0] pids [4] = '{`UTS_PID_OUT, `UTS_PID_IN, `UTS_PID_SETUP, `UTS_PID_SOF};
  // Short suspend count keeps the run brief
  uts_regs #(.SUSPEND_CYC(16)) uts_regs_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pkt_valid(pv), .i_pkt_pid(pid),
    .i_tok_valid(tv), .i_tok_ep(tep), .i_tok_frame(tfr), .o_rx_ep(rx_ep), .o_rx_ep_valid(rx_v),
    .i_line_pin(lp), .o_line_filt(filt), .o_usb_data_port_a_pd_en(pd_a), .o_usb_data_port_b_pd_en(pd_b),
    .o_transceiver_config_pins(conf), .o_suspended(susp), .o_irq(irq));
  uts_host_model uts_host_model_i (.i_sys_clk(i_sys_clk), .o_pkt_valid(pv), .o_pkt_pid(pid),
    .o_tok_valid(tv), .o_tok_ep(tep), .o_tok_frame(tfr), .o_line_pin(lp));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Expected receive port value for a marked or plain endpoint
  function automatic logic [4:0] rx_exp(input logic [15:0] m, input logic [3:0] e);
    return {m[e], e};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    {i_resetn, i_wr, i_rd, i_addr, i_wdata} = '0;
    {num_errors, n_tests, cyc} = '0;
    ep_ok = 1'b0;
    d = $urandom(32'ha73b);
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    // Reset values of every register but the line word
    for (int a = 8'h28; a <= 8'h48; a += 4)
    begin
      rd(8'(a), got);
      chk("reset value", 32'h0, got);
    end
    chk("pulldown reset", 32'h1, 32'(pd_a));
    $display("reset test done");
    // Random read-back of writable fields, read-only and unmapped places
    repeat (8)
    begin
      d = $urandom;
      wr(`UTS_OFF_SOF, d);
      rd(`UTS_OFF_SOF, got);
      chk("frame", d & 32'h7ff, got);
      wr(`UTS_OFF_EPMARK, d);
      rd(`UTS_OFF_EPMARK, got);
      chk("mark", d & 32'hffff, got);
      wr(`UTS_OFF_PID, d);
      rd(`UTS_OFF_PID, got);
      chk("identifier", 32'h0, got);
      wr(`UTS_OFF_XCTL, d);
      rd(`UTS_OFF_XCTL, got);
      chk("control", d & 32'h0004_0ff0, got);
      chk("pulldown", 32'(!d[18]), 32'(pd_b));
      chk("config", 32'(d[6:4]), 32'(conf));
    end
    wr(`UTS_OFF_OTGMASK, d);
    rd(`UTS_OFF_OTGMASK, got);
    chk("flag mask", d, got);
    wr(`UTS_OFF_PWRSIG, d);
    rd(`UTS_OFF_PWRSIG, got);
    chk("power word", d & 32'h1ff, got);
    rd(8'h50, got);
    chk("unmapped", 32'h0, got);
    $display("register test done");
    // Tokens of every kind with random marks
    mark = 16'($urandom);
    wr(`UTS_OFF_EPMARK, 32'(mark));
    repeat (12)
    begin
      ep = 4'($urandom);
      fr = 11'($urandom);
      d[3:0] = pids[$urandom % 4];
      uts_host_model_i.send_token(d[3:0], ep, fr);
      #1 chk("rx strobe", 32'(d[3:0] != `UTS_PID_SOF), 32'(rx_v));
      if (d[3:0] != `UTS_PID_SOF)
      begin
        chk("rx endpoint", 32'(rx_exp(mark, ep)), 32'(rx_ep));
        last_ep = ep;
        ep_ok = 1'b1;
      end
      rd(`UTS_OFF_PID, got);
      chk("identifier", 32'(d[3:0]), got);
      rd(`UTS_OFF_EP, got);
      chk("endpoint", ep_ok ? 32'({1'b1, last_ep}) : 32'h0, got);
      rd(`UTS_OFF_SOF, got);
      if (d[3:0] == `UTS_PID_SOF)
        chk("frame load", 32'(fr), got);
    end
    $display("token test done");
    // Start-of-frame interrupt unmasked, then masked
    rd(`UTS_OFF_IRQ_STAT, got);
    for (int m = 1; m >= 0; m--)
    begin
      wr(`UTS_OFF_IRQ_MASK, 32'(m));
      uts_host_model_i.send_token(`UTS_PID_SOF, 4'h0, 11'h7ff);
      repeat (3) @(posedge i_sys_clk);
      #1 chk("irq raised", 32'(m), 32'(irq));
      rd(`UTS_OFF_IRQ_STAT, got);
      chk("sof status", 32'h1, got);
      repeat (2) @(posedge i_sys_clk);
      #1 chk("irq cleared", 32'h0, 32'(irq));
    end
    $display("interrupt test done");
    // Suspend then SE0 without, SE0 with and K with auto-resume
    wr(`UTS_OFF_IRQ_MASK, 32'h6);
    for (int k = 0; k < 3; k++)
    begin
      wr(`UTS_OFF_XCTL, 32'h200 | (k > 0 ? 32'h80 : 32'h0));
      for (int w = 0; w < 300 && susp !== 1'b1; w++)
        @(posedge i_sys_clk);
      chk("suspend entered", 32'h1, 32'(susp));
      uts_host_model_i.drive_line(k == 2 ? UTS_LS_K : UTS_LS_SE0);
      repeat (2) @(posedge i_sys_clk);
      #1 chk("filter early", 32'(UTS_LS_J), 32'(filt));
      repeat (12) @(posedge i_sys_clk);
      #1 chk("filter late", k == 2 ? 32'(UTS_LS_K) : 32'(UTS_LS_SE0), 32'(filt));
      chk("resume irq", 32'(k > 0), 32'(irq));
      chk("suspend left", 32'h0, 32'(susp));
      rd(`UTS_OFF_LINE, got);
      chk("line word", k == 2 ? 32'h2 : 32'h0, got);
      rd(`UTS_OFF_XCTL, got);
      chk("resume flags", k == 0 ? 32'h0 : (k == 1 ? 32'h2000 : 32'h1000), got & 32'h3000);
      rd(`UTS_OFF_IRQ_STAT, got);
      chk("resume status", k == 0 ? 32'h0 : (k == 1 ? 32'h2 : 32'h4), got & 32'h6);
      wr(`UTS_OFF_XCTL, 32'h200);
      rd(`UTS_OFF_XCTL, got);
      chk("flags cleared", 32'h0, got & 32'h3000);
      uts_host_model_i.drive_line(UTS_LS_J);
    end
    $display("resume test done");
    summarize();
  end
endmodule
